// ===== ccri_core.sv
// Core special registers (stack pointer, data pointer, status word, accumulator,
// second operand) and interrupt entry for 22 sources with two levels.
// Assumes the instruction sequencer pulses instr_done at each instruction end,
// performs the call itself on vec_take and pushes/pops via push_req/pop_req.
`timescale 1ns/1ns
`include "ccri_regs.svh"
module ccri_core #(
	parameter int                  NSRC       = `CCRI_NSRC,
	parameter logic [`CCRI_NSRC-1:0] HW_CLR_MASK = `CCRI_HW_CLR_MASK
) (
	input  wire logic                    core_clk,     // System clock, 20 MHz
	input  wire logic                    rst_n,        // Synchronous reset, active low
	input  wire logic [7:0]              sfr_addr,     // Register address
	input  wire logic                    sfr_wr,       // Register write strobe
	input  wire logic                    sfr_rd,       // Register read strobe
	input  wire logic [7:0]              sfr_wdata,    // Register write data
	output logic      [7:0]              sfr_rdata,    // Register read data
	input  wire logic                    push_req,     // Stack push
	input  wire logic                    pop_req,      // Stack pop
	output logic      [7:0]              stack_ptr,    // Stack top
	output logic      [15:0]             data_ptr,     // 16-bit data pointer
	input  wire logic [2:0]              reg_num,      // Working register number
	output logic      [7:0]              reg_ram_addr, // Internal RAM address of it
	input  wire logic                    alu_go,       // Arithmetic operation strobe
	input  wire ccri_pkg::ccri_alu_op_t  alu_op,       // Arithmetic operation
	input  wire logic [7:0]              alu_opnd,     // Second operand of add/subtract
	input  wire logic [NSRC-1:0]         src_event,    // Source valid conditions
	input  wire logic                    instr_done,   // Current instruction finished
	input  wire logic                    interrupt_return_instr_done,    // Finished one is a return
	output logic                         vec_take,     // Vector call now
	output logic      [15:0]             vec_addr,     // Vector address
	output logic      [NSRC-1:0]         pend_flags    // Pending flags
);
	logic [7:0]      sp_reg, sp_next, dpl_reg, dph_reg, psw_reg, psw_next;
	logic [7:0]      acc_reg, acc_next, b_reg, b_next, en0_reg;
	logic [NSRC-1:0] en_reg, pri_reg, pend_reg, pend_next;
	logic            act_hi_reg, act_lo_reg, take_reg;
	logic [15:0]     vaddr_reg;
	logic [7:0]      rdata_reg;

	ccri_arb_if #(.NSRC(NSRC)) arb_bus ();
	ccri_irq_arb #(.NSRC(NSRC)) u_arb (.a(arb_bus));

	// Write decode
	wire wr_sp   = sfr_wr && (sfr_addr == `CCRI_ADDR_SP);
	wire wr_dpl  = sfr_wr && (sfr_addr == `CCRI_ADDR_DPL);
	wire wr_dph  = sfr_wr && (sfr_addr == `CCRI_ADDR_DPH);
	wire wr_psw  = sfr_wr && (sfr_addr == `CCRI_ADDR_PSW);
	wire wr_acc  = sfr_wr && (sfr_addr == `CCRI_ADDR_ACC);
	wire wr_b    = sfr_wr && (sfr_addr == `CCRI_ADDR_B);
	wire wr_en0  = sfr_wr && (sfr_addr == `CCRI_ADDR_EN0);
	wire wr_en1  = sfr_wr && (sfr_addr == `CCRI_ADDR_EN1);
	wire wr_en2  = sfr_wr && (sfr_addr == `CCRI_ADDR_EN2);
	wire wr_pri0 = sfr_wr && (sfr_addr == `CCRI_ADDR_PRI0);
	wire wr_pri1 = sfr_wr && (sfr_addr == `CCRI_ADDR_PRI1);
	wire wr_pri2 = sfr_wr && (sfr_addr == `CCRI_ADDR_PRI2);
	wire wr_pnd0 = sfr_wr && (sfr_addr == `CCRI_ADDR_PND0);
	wire wr_pnd1 = sfr_wr && (sfr_addr == `CCRI_ADDR_PND1);
	wire wr_pnd2 = sfr_wr && (sfr_addr == `CCRI_ADDR_PND2);

	// Sources 0-6 sit in the first byte, 7-14 in the second, 15-21 in the third
	wire [NSRC-1:0] wr_vec   = {sfr_wdata[6:0], sfr_wdata, sfr_wdata[6:0]};
	wire [NSRC-1:0] sel_en   = {{7{wr_en2}}, {8{wr_en1}}, {7{wr_en0}}};
	wire [NSRC-1:0] sel_pri  = {{7{wr_pri2}}, {8{wr_pri1}}, {7{wr_pri0}}};
	wire [NSRC-1:0] sel_pnd  = {{7{wr_pnd2}}, {8{wr_pnd1}}, {7{wr_pnd0}}};
	wire            glob_en  = en0_reg[`CCRI_EN_GLOBAL];

	// Odd parity of the accumulator, never stored
	wire            parity   = ^acc_reg;
	wire [7:0]      psw_view = {psw_reg[7:1], parity};

	// Register bank mapping
	assign reg_ram_addr = {3'b000, psw_reg[`CCRI_PSW_RS_HI:`CCRI_PSW_RS_LO], reg_num};
	assign data_ptr     = {dph_reg, dpl_reg};
	assign stack_ptr    = sp_reg;
	assign pend_flags   = pend_reg;
	assign sfr_rdata    = rdata_reg;
	assign vec_take     = take_reg;
	assign vec_addr     = vaddr_reg;

	// Read mux; unmapped addresses read zero
	wire [7:0] rd_mux =
		(sfr_addr == `CCRI_ADDR_SP)   ? sp_reg :
		(sfr_addr == `CCRI_ADDR_DPL)  ? dpl_reg :
		(sfr_addr == `CCRI_ADDR_DPH)  ? dph_reg :
		(sfr_addr == `CCRI_ADDR_PSW)  ? psw_view :
		(sfr_addr == `CCRI_ADDR_ACC)  ? acc_reg :
		(sfr_addr == `CCRI_ADDR_B)    ? b_reg :
		(sfr_addr == `CCRI_ADDR_EN0)  ? {glob_en, en_reg[6:0]} :
		(sfr_addr == `CCRI_ADDR_EN1)  ? en_reg[14:7] :
		(sfr_addr == `CCRI_ADDR_EN2)  ? {1'b0, en_reg[21:15]} :
		(sfr_addr == `CCRI_ADDR_PRI0) ? {1'b0, pri_reg[6:0]} :
		(sfr_addr == `CCRI_ADDR_PRI1) ? pri_reg[14:7] :
		(sfr_addr == `CCRI_ADDR_PRI2) ? {1'b0, pri_reg[21:15]} :
		(sfr_addr == `CCRI_ADDR_PND0) ? {1'b0, pend_reg[6:0]} :
		(sfr_addr == `CCRI_ADDR_PND1) ? pend_reg[14:7] :
		(sfr_addr == `CCRI_ADDR_PND2) ? {1'b0, pend_reg[21:15]} :
		`CCRI_ZERO8;

	// Stack pointer: a push moves to the next free byte before it is written
	wire [7:0] sp_step = push_req && !pop_req ? 8'h01 : (pop_req && !push_req ? 8'hff : 8'h00);
	assign sp_next = wr_sp ? sfr_wdata : sp_reg + sp_step;

	// Arithmetic
	wire       cin      = (alu_op == ccri_pkg::ALU_SUM_WITH_CARRY_INSTR || alu_op == ccri_pkg::ALU_DIFFERENCE_WITH_BORROW_INSTR) &&
	                      psw_reg[`CCRI_PSW_CY];
	wire [8:0] add_full = {1'b0, acc_reg} + {1'b0, alu_opnd} + {8'h00, cin};
	wire [4:0] add_nib  = {1'b0, acc_reg[3:0]} + {1'b0, alu_opnd[3:0]} + {4'h0, cin};
	wire [8:0] sub_full = {1'b0, acc_reg} - {1'b0, alu_opnd} - {8'h00, cin};
	wire [4:0] sub_nib  = {1'b0, acc_reg[3:0]} - {1'b0, alu_opnd[3:0]} - {4'h0, cin};
	wire       add_ov   = (acc_reg[7] == alu_opnd[7]) && (add_full[7] != acc_reg[7]);
	wire       sub_ov   = (acc_reg[7] != alu_opnd[7]) && (sub_full[7] != acc_reg[7]);
	wire [15:0] prod    = acc_reg * b_reg;
	wire        div_z   = (b_reg == `CCRI_ZERO8);
	// Zero divisor leaves the operands untouched so software can inspect them
	wire [7:0]  quot    = div_z ? acc_reg : acc_reg / b_reg;
	wire [7:0]  rem     = div_z ? b_reg : acc_reg % b_reg;

	always_comb begin
		acc_next = acc_reg;
		b_next   = b_reg;
		psw_next = psw_reg;
		if (alu_go) begin
			case (alu_op)
				ccri_pkg::ALU_ADD, ccri_pkg::ALU_SUM_WITH_CARRY_INSTR: begin
					acc_next                = add_full[7:0];
					psw_next[`CCRI_PSW_CY]  = add_full[8];
					psw_next[`CCRI_PSW_AC]  = add_nib[4];
					psw_next[`CCRI_PSW_OV]  = add_ov;
				end
				ccri_pkg::ALU_DIFFERENCE_WITH_BORROW_INSTR: begin
					acc_next                = sub_full[7:0];
					psw_next[`CCRI_PSW_CY]  = sub_full[8];
					psw_next[`CCRI_PSW_AC]  = sub_nib[4];
					psw_next[`CCRI_PSW_OV]  = sub_ov;
				end
				ccri_pkg::ALU_MUL: begin
					acc_next                = prod[7:0];
					b_next                  = prod[15:8];
					psw_next[`CCRI_PSW_CY]  = 1'b0;
					psw_next[`CCRI_PSW_AC]  = 1'b0;
					psw_next[`CCRI_PSW_OV]  = (prod[15:8] != `CCRI_ZERO8);
				end
				ccri_pkg::ALU_DIV: begin
					acc_next                = quot;
					b_next                  = rem;
					psw_next[`CCRI_PSW_CY]  = 1'b0;
					psw_next[`CCRI_PSW_AC]  = 1'b0;
					psw_next[`CCRI_PSW_OV]  = div_z;
				end
				default: begin
					psw_next = psw_reg;
				end
			endcase
		end
		// Software write wins over an arithmetic result in the same cycle
		if (wr_acc)
			acc_next = sfr_wdata;
		if (wr_b)
			b_next = sfr_wdata;
		if (wr_psw)
			psw_next = {sfr_wdata[7:1], 1'b0};
	end

	// Interrupt requests
	wire [NSRC-1:0] pend_en = pend_reg & en_reg;
	assign arb_bus.req      = pend_en & {NSRC{glob_en}};
	assign arb_bus.hi       = pri_reg;
	assign arb_bus.allow_hi = !act_hi_reg;
	assign arb_bus.allow_lo = !act_hi_reg && !act_lo_reg;

	// Vector only at an instruction boundary that is not a return
	wire take_now = instr_done && !interrupt_return_instr_done && arb_bus.win_valid && !take_reg;
	wire [NSRC-1:0] win_oh   = {{(NSRC-1){1'b0}}, 1'b1} << arb_bus.win_idx;
	wire [NSRC-1:0] hw_clr   = take_now ? (win_oh & HW_CLR_MASK) : '0;
	wire [NSRC-1:0] sw_clr   = sel_pnd & ~wr_vec;
	wire [NSRC-1:0] pnd_set  = src_event | (sel_pnd & wr_vec);
	// A set in the same cycle as a clear is kept
	assign pend_next = (pend_reg & ~(hw_clr | sw_clr)) | pnd_set;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			sp_reg   <= `CCRI_SP_RST;
			dpl_reg  <= `CCRI_ZERO8;
			dph_reg  <= `CCRI_ZERO8;
			psw_reg  <= `CCRI_ZERO8;
			acc_reg  <= `CCRI_ZERO8;
			b_reg    <= `CCRI_ZERO8;
		end else begin
			sp_reg   <= sp_next;
			dpl_reg  <= wr_dpl ? sfr_wdata : dpl_reg;
			dph_reg  <= wr_dph ? sfr_wdata : dph_reg;
			psw_reg  <= psw_next;
			acc_reg  <= acc_next;
			b_reg    <= b_next;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			en0_reg  <= `CCRI_ZERO8;
			en_reg   <= '0;
			pri_reg  <= '0;
			pend_reg <= '0;
		end else begin
			en0_reg  <= wr_en0 ? sfr_wdata : en0_reg;
			en_reg   <= (en_reg & ~sel_en) | (wr_vec & sel_en);
			pri_reg  <= (pri_reg & ~sel_pri) | (wr_vec & sel_pri);
			pend_reg <= pend_next;
		end
	end

	// In-service levels: a return closes the innermost active level
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			act_hi_reg <= 1'b0;
			act_lo_reg <= 1'b0;
			take_reg   <= 1'b0;
			vaddr_reg  <= 16'h0000;
			rdata_reg  <= `CCRI_ZERO8;
		end else begin
			take_reg <= take_now;
			if (take_now)
				vaddr_reg <= {`CCRI_VEC_HIGH, arb_bus.win_idx, `CCRI_VEC_LOW3};
			if (take_now && arb_bus.win_hi)
				act_hi_reg <= 1'b1;
			else if (instr_done && interrupt_return_instr_done && act_hi_reg)
				act_hi_reg <= 1'b0;
			if (take_now && !arb_bus.win_hi)
				act_lo_reg <= 1'b1;
			else if (instr_done && interrupt_return_instr_done && !act_hi_reg)
				act_lo_reg <= 1'b0;
			if (sfr_rd)
				rdata_reg <= rd_mux;
		end
	end

	default clocking cb @(posedge core_clk); endclocking

	a_sp_reset_val: assert property (!rst_n |=> sp_reg == `CCRI_SP_RST)
		else $error("stack pointer not 0x07 after reset");
	a_sp_push_step: assert property (disable iff (!rst_n)
		push_req && !pop_req && !wr_sp |=> sp_reg == $past(sp_reg) + 8'h01)
		else $error("stack pointer did not step up on push");
	a_data_pointer_16_high_byte: assert property (disable iff (!rst_n)
		wr_dph |=> data_ptr[15:8] == $past(sfr_wdata) && data_ptr[7:0] == $past(dpl_reg))
		else $error("data pointer high byte wrong");
	a_add_carry_out: assert property (disable iff (!rst_n)
		alu_go && alu_op == ccri_pkg::ALU_ADD && !wr_psw
		|=> psw_reg[`CCRI_PSW_CY] ==
		(({1'b0, $past(acc_reg)} + {1'b0, $past(alu_opnd)}) >= 9'h100))
		else $error("carry wrong after add");
	a_sub_aux_borrow: assert property (disable iff (!rst_n)
		alu_go && alu_op == ccri_pkg::ALU_DIFFERENCE_WITH_BORROW_INSTR && !wr_psw
		|=> psw_reg[`CCRI_PSW_AC] == ({1'b0, $past(acc_reg[3:0])} <
		({1'b0, $past(alu_opnd[3:0])} + {4'h0, $past(psw_reg[`CCRI_PSW_CY])})))
		else $error("aux carry wrong after subtract");
	a_user_flags_kept: assert property (disable iff (!rst_n)
		!wr_psw |=> $stable(psw_reg[`CCRI_PSW_F0]) && $stable(psw_reg[`CCRI_PSW_F1]))
		else $error("user flag changed without a write");
	a_bank_addr_map: assert property (disable iff (!rst_n)
		wr_psw |=> reg_ram_addr[4:3] == $past(sfr_wdata[4:3]))
		else $error("bank select does not steer register address");
	a_mul_overflow: assert property (disable iff (!rst_n)
		alu_go && alu_op == ccri_pkg::ALU_MUL && !wr_psw
		|=> psw_reg[`CCRI_PSW_OV] == ((16'($past(acc_reg)) * 16'($past(b_reg))) > 16'h00ff))
		else $error("overflow disagrees with product size");
	a_div_overflow: assert property (disable iff (!rst_n)
		alu_go && alu_op == ccri_pkg::ALU_DIV && !wr_psw
		|=> psw_reg[`CCRI_PSW_OV] == ($past(b_reg) == `CCRI_ZERO8))
		else $error("overflow wrong after divide");
	a_parity_follows: assert property (disable iff (!rst_n)
		sfr_rd && sfr_addr == `CCRI_ADDR_PSW |=> sfr_rdata[`CCRI_PSW_PAR] == ^$past(acc_reg))
		else $error("parity bit does not match accumulator");
	a_b_reset_zero: assert property (!rst_n |=> b_reg == `CCRI_ZERO8)
		else $error("second operand not zero after reset");
	a_pend_event_set: assert property (disable iff (!rst_n)
		|src_event |=> (pend_reg & $past(src_event)) == $past(src_event))
		else $error("event lost from pending flags");
	a_vec_enabled_only: assert property (disable iff (!rst_n)
		take_now |-> glob_en && en_reg[arb_bus.win_idx] && pend_reg[arb_bus.win_idx])
		else $error("vectored to a disabled source");
	a_vec_after_done: assert property (disable iff (!rst_n)
		vec_take |-> $past(instr_done) && !$past(interrupt_return_instr_done))
		else $error("vector call not at an instruction end");
	a_hi_not_preempt: assert property (disable iff (!rst_n)
		act_hi_reg && !(instr_done && interrupt_return_instr_done) |=> !vec_take)
		else $error("high handler preempted");
	a_hi_first: assert property (disable iff (!rst_n)
		take_now && |(arb_bus.req & pri_reg) && !act_hi_reg |-> arb_bus.win_hi)
		else $error("low request served before high");

	c_vector_taken: cover property (disable iff (!rst_n) vec_take);
	c_preempt_low: cover property (disable iff (!rst_n) act_lo_reg && take_now && arb_bus.win_hi);
	c_reenter: cover property (disable iff (!rst_n)
		instr_done && interrupt_return_instr_done ##[1:20] vec_take);
	c_soft_pend: cover property (disable iff (!rst_n) |(sel_pnd & wr_vec) ##[1:10] vec_take);
endmodule : ccri_core

// ===== ccri_regs.svh
// Register addresses, reset values, flag positions and vector layout for the core
// registers and interrupt entry logic. Definitions only; included by bare name.
`ifndef CCRI_REGS_SVH
`define CCRI_REGS_SVH

`define CCRI_ADDR_SP      8'h81
`define CCRI_ADDR_DPL     8'h82
`define CCRI_ADDR_DPH     8'h83
`define CCRI_ADDR_PSW     8'hd0
`define CCRI_ADDR_ACC     8'he0
`define CCRI_ADDR_B       8'hf0
`define CCRI_ADDR_EN0     8'ha8
`define CCRI_ADDR_EN1     8'he6
`define CCRI_ADDR_EN2     8'he7
`define CCRI_ADDR_PRI0    8'hb8
`define CCRI_ADDR_PRI1    8'hf6
`define CCRI_ADDR_PRI2    8'hf7
`define CCRI_ADDR_PND0    8'h9c
`define CCRI_ADDR_PND1    8'h9e
`define CCRI_ADDR_PND2    8'h9f

`define CCRI_SP_RST       8'h07
`define CCRI_ZERO8        8'h00

`define CCRI_PSW_CY       7
`define CCRI_PSW_AC       6
`define CCRI_PSW_F0       5
`define CCRI_PSW_RS_HI    4
`define CCRI_PSW_RS_LO    3
`define CCRI_PSW_OV       2
`define CCRI_PSW_F1       1
`define CCRI_PSW_PAR      0
`define CCRI_EN_GLOBAL    7

`define CCRI_NSRC         22
`define CCRI_HW_CLR_MASK  22'h08000f
`define CCRI_VEC_LOW3     3'b011
`define CCRI_VEC_HIGH     8'h00

`endif

// ===== ccri_pkg.sv
// Shared types for the core register file and interrupt entry.
// Assumes ccri_regs.svh supplies the numeric layout.
package ccri_pkg;
	typedef enum logic [2:0] {
		ALU_ADD,
		ALU_SUM_WITH_CARRY_INSTR,
		ALU_DIFFERENCE_WITH_BORROW_INSTR,
		ALU_MUL,
		ALU_DIV
	} ccri_alu_op_t;

	typedef logic [4:0] ccri_src_idx_t;
endpackage : ccri_pkg

// ===== ccri_arb_if.sv
// Request and winner signals between the register core and its arbiter.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface ccri_arb_if #(
	parameter int NSRC = 22
);
	logic [NSRC-1:0]        req;
	logic [NSRC-1:0]        hi;
	logic                   allow_hi;
	logic                   allow_lo;
	logic                   win_valid;
	ccri_pkg::ccri_src_idx_t win_idx;
	logic                   win_hi;

	modport core (output req, hi, allow_hi, allow_lo, input win_valid, win_idx, win_hi);
	modport arb (input req, hi, allow_hi, allow_lo, output win_valid, win_idx, win_hi);
endinterface : ccri_arb_if

// ===== ccri_irq_arb.sv
// Two-level fixed-order interrupt arbiter, purely combinational.
// Assumes req already carries pending, source enable and global enable.
`timescale 1ns/1ns
module ccri_irq_arb #(
	parameter int NSRC = 22
) (
	ccri_arb_if.arb a   // Requests in, winner out
);
	logic                    hi_found;
	logic                    lo_found;
	ccri_pkg::ccri_src_idx_t hi_idx;
	ccri_pkg::ccri_src_idx_t lo_idx;

	// Downward scan leaves the lowest-numbered source, which is first in fixed order
	always_comb begin
		hi_found = 1'b0;
		lo_found = 1'b0;
		hi_idx   = '0;
		lo_idx   = '0;
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (a.req[i] && a.hi[i]) begin
				hi_found = 1'b1;
				hi_idx   = ccri_pkg::ccri_src_idx_t'(i);
			end
			if (a.req[i] && !a.hi[i]) begin
				lo_found = 1'b1;
				lo_idx   = ccri_pkg::ccri_src_idx_t'(i);
			end
		end
	end

	wire use_hi = hi_found && a.allow_hi;
	wire use_lo = lo_found && a.allow_lo;

	assign a.win_valid = use_hi || use_lo;
	assign a.win_hi    = use_hi;
	assign a.win_idx   = use_hi ? hi_idx : lo_idx;
endmodule : ccri_irq_arb

// ===== ccri_src_model.sv
// Model of the on-chip peripherals and pins that raise interrupt source conditions.
// Assumes the bench requests one event at a time, on the core clock.
`timescale 1ns/1ns
module ccri_src_model #(
	parameter int NSRC = 22
) (
	input  wire logic            core_clk,  // System clock
	input  wire logic            rst_n,     // Synchronous reset, active low
	input  wire logic            fire,      // Raise one valid condition
	input  wire logic [4:0]      fire_idx,  // Source that meets its condition
	output logic      [NSRC-1:0] src_event  // Valid conditions to the core
);
	// Edge-type peripherals give one-cycle pulses, the hardest case for flag capture
	always_ff @(posedge core_clk) begin
		if (!rst_n)
			src_event <= '0;
		else
			src_event <= fire ? (NSRC'(1) << fire_idx) : '0;
	end
endmodule : ccri_src_model

// ===== tb.sv
// Self-checking bench for the core registers and interrupt entry.
// Assumes ccri_core defaults and the source model beside it.
`timescale 1ns/1ns
`include "ccri_regs.svh"
module tb;
	logic                   core_clk, rst_n, sfr_wr, sfr_rd, push_req, pop_req;
	logic                   alu_go, instr_done, interrupt_return_instr_done, fire, vec_take;
	logic [7:0]             sfr_addr, sfr_wdata, sfr_rdata, alu_opnd, stack_ptr, reg_ram_addr;
	logic [2:0]             reg_num;
	logic [4:0]             fire_idx;
	logic [15:0]            data_ptr, vec_addr;
	logic [21:0]            src_event, pend_flags;
	ccri_pkg::ccri_alu_op_t alu_op;
	int                     fail_count, checks_done, cycles;

	ccri_core i_ccri_core (.core_clk(core_clk), .rst_n(rst_n), .sfr_addr(sfr_addr),
		.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
		.push_req(push_req), .pop_req(pop_req), .stack_ptr(stack_ptr), .data_ptr(data_ptr),
		.reg_num(reg_num), .reg_ram_addr(reg_ram_addr), .alu_go(alu_go), .alu_op(alu_op),
		.alu_opnd(alu_opnd), .src_event(src_event), .instr_done(instr_done),
		.interrupt_return_instr_done(interrupt_return_instr_done), .vec_take(vec_take), .vec_addr(vec_addr),
		.pend_flags(pend_flags));
	ccri_src_model i_ccri_src_model (.core_clk(core_clk), .rst_n(rst_n), .fire(fire),
		.fire_idx(fire_idx), .src_event(src_event));

	task print_verdict;
		$display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : print_verdict

	task chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		@(posedge core_clk);
		sfr_wr <= 1'b0;
		#1;
	endtask : wr

	task rdc(input logic [7:0] a, input logic [7:0] e);
		@(posedge core_clk);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge core_clk);
		sfr_rd <= 1'b0;
		#1;
		chk({8'h00, sfr_rdata}, {8'h00, e});
	endtask : rdc

	task arow(input ccri_pkg::ccri_alu_op_t op, input logic [7:0] a, input logic [7:0] b,
		input logic [7:0] opnd, input logic [7:0] ea, input logic [7:0] eb,
		input logic [7:0] ep);
		wr(`CCRI_ADDR_ACC, a);
		wr(`CCRI_ADDR_B, b);
		@(posedge core_clk);
		alu_go <= 1'b1;
		alu_op <= op;
		alu_opnd <= opnd;
		@(posedge core_clk);
		alu_go <= 1'b0;
		rdc(`CCRI_ADDR_ACC, ea);
		rdc(`CCRI_ADDR_B, eb);
		rdc(`CCRI_ADDR_PSW, ep);
	endtask : arow

	// The take is judged one edge after the boundary edge, when vec_take has landed
	task step(input logic r, input logic et, input logic [15:0] ea);
		@(posedge core_clk);
		instr_done <= 1'b1;
		interrupt_return_instr_done <= r;
		@(posedge core_clk);
		instr_done <= 1'b0;
		interrupt_return_instr_done <= 1'b0;
		#1;
		chk({15'h0000, vec_take}, {15'h0000, et});
		if (et)
			chk(vec_addr, ea);
	endtask : step

	task raise(input logic [4:0] idx);
		@(posedge core_clk);
		fire <= 1'b1;
		fire_idx <= idx;
		@(posedge core_clk);
		fire <= 1'b0;
		@(posedge core_clk);
		#1;
	endtask : raise

	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	// Tests need a few hundred cycles; the ceiling leaves ample margin
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 3000) begin
			fail_count++;
			print_verdict();
		end
	end

	initial begin
		{rst_n, sfr_wr, sfr_rd, push_req, pop_req, alu_go, instr_done, interrupt_return_instr_done, fire} = '0;
		{sfr_addr, sfr_wdata, alu_opnd, fire_idx} = '0;
		reg_num = 3'd5;
		alu_op = ccri_pkg::ALU_ADD;
		fail_count = 0;
		checks_done = 0;
		cycles = 0;
		repeat (3) @(posedge core_clk);
		rst_n <= 1'b1;
		rdc(`CCRI_ADDR_SP, 8'h07);
		rdc(`CCRI_ADDR_B, 8'h00);
		rdc(`CCRI_ADDR_PSW, 8'h00);
		rdc(`CCRI_ADDR_DPH, 8'h00);
		@(posedge core_clk);
		push_req <= 1'b1;
		@(posedge core_clk);
		push_req <= 1'b0;
		#1;
		chk({8'h00, stack_ptr}, 16'h0008);
		@(posedge core_clk);
		pop_req <= 1'b1;
		@(posedge core_clk);
		pop_req <= 1'b0;
		#1;
		chk({8'h00, stack_ptr}, 16'h0007);
		wr(`CCRI_ADDR_DPL, 8'h34);
		wr(`CCRI_ADDR_DPH, 8'h12);
		chk(data_ptr, 16'h1234);
		wr(8'h85, 8'h00);
		rdc(8'h85, 8'h00);
		wr(`CCRI_ADDR_PSW, 8'h3b);
		rdc(`CCRI_ADDR_PSW, 8'h3a);
		for (int b = 0; b < 4; b++) begin
			wr(`CCRI_ADDR_PSW, 8'((b << 3) | 8'h22));
			chk({8'h00, reg_ram_addr}, 16'((b << 3) | 5));
		end
		wr(`CCRI_ADDR_PSW, 8'h22);
		arow(ccri_pkg::ALU_ADD, 8'h8f, 8'h00, 8'h71, 8'h00, 8'h00, 8'he2);
		arow(ccri_pkg::ALU_ADD, 8'h40, 8'h00, 8'h40, 8'h80, 8'h00, 8'h27);
		arow(ccri_pkg::ALU_DIFFERENCE_WITH_BORROW_INSTR, 8'h80, 8'h00, 8'h01, 8'h7f, 8'h00, 8'h67);
		arow(ccri_pkg::ALU_DIFFERENCE_WITH_BORROW_INSTR, 8'h00, 8'h00, 8'h01, 8'hff, 8'h00, 8'he2);
		arow(ccri_pkg::ALU_SUM_WITH_CARRY_INSTR, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h23);
		arow(ccri_pkg::ALU_MUL, 8'h10, 8'h20, 8'h00, 8'h00, 8'h02, 8'h26);
		arow(ccri_pkg::ALU_MUL, 8'h03, 8'h05, 8'h00, 8'h0f, 8'h00, 8'h22);
		arow(ccri_pkg::ALU_DIV, 8'h07, 8'h02, 8'h00, 8'h03, 8'h01, 8'h22);
		arow(ccri_pkg::ALU_DIV, 8'h05, 8'h00, 8'h00, 8'h05, 8'h00, 8'h26);
		wr(`CCRI_ADDR_EN0, 8'ha0);
		raise(5'd5);
		chk({15'h0000, pend_flags[5]}, 16'h0001);
		step(1'b0, 1'b1, 16'h002b);
		chk({15'h0000, pend_flags[5]}, 16'h0001);
		step(1'b1, 1'b0, 16'h0000);
		step(1'b0, 1'b1, 16'h002b);
		wr(`CCRI_ADDR_PND0, 8'h00);
		step(1'b1, 1'b0, 16'h0000);
		step(1'b0, 1'b0, 16'h0000);
		wr(`CCRI_ADDR_EN0, 8'h08);
		wr(`CCRI_ADDR_EN1, 8'h02);
		wr(`CCRI_ADDR_PRI1, 8'h02);
		wr(`CCRI_ADDR_PND0, 8'h08);
		wr(`CCRI_ADDR_PND1, 8'h02);
		step(1'b0, 1'b0, 16'h0000);
		wr(`CCRI_ADDR_EN0, 8'h88);
		step(1'b0, 1'b1, 16'h0043);
		step(1'b0, 1'b0, 16'h0000);
		wr(`CCRI_ADDR_PND1, 8'h00);
		step(1'b1, 1'b0, 16'h0000);
		step(1'b0, 1'b1, 16'h001b);
		chk({15'h0000, pend_flags[3]}, 16'h0000);
		raise(5'd8);
		step(1'b0, 1'b1, 16'h0043);
		wr(`CCRI_ADDR_PND1, 8'h00);
		step(1'b1, 1'b0, 16'h0000);
		step(1'b1, 1'b0, 16'h0000);
		wr(`CCRI_ADDR_PND0, 8'h20);
		step(1'b0, 1'b0, 16'h0000);
		wr(`CCRI_ADDR_EN2, 8'h10);
		rdc(`CCRI_ADDR_EN2, 8'h10);
		wr(`CCRI_ADDR_PND2, 8'h10);
		step(1'b0, 1'b1, 16'h009b);
		chk({15'h0000, pend_flags[19]}, 16'h0000);
		step(1'b1, 1'b0, 16'h0000);
		print_verdict();
	end
endmodule : tb
